// >>> hw/cmp_core_regs.sv
// Core mode, privilege and register-set logic.
// Assumes an instruction pipeline drives the request ports on sys_clk and
// a memory answers vector fetches with mem_valid.
`timescale 1ns/1ps
`default_nettype none

module cmp_core_regs #(
   parameter int EXC_W = 9
) (
   input wire logic sys_clk,
   input wire logic nrst,
   // Vector fetch port
   output logic mem_req,
   output logic [31:0] mem_addr,
   input wire logic mem_valid,
   input wire logic [31:0] mem_rdata,
   // Exception entry and return
   input wire logic exc_enter,
   input wire logic [8:0] exc_num,
   input wire logic exc_return,
   input wire logic svc_exec,
   // General register port
   input wire cmp_pkg::cmp_gpr_req_t gpr_req,
   input wire logic [3:0] gpr_rd_num,
   output logic [31:0] gpr_rd_data,
   // Push request
   input wire logic push,
   output logic [31:0] push_addr,
   // Special-register moves
   input wire cmp_pkg::cmp_spec_req_t spec_req,
   output logic [31:0] spec_rd_data,
   output logic spec_denied,
   // Change-state and system resource checks, and the application flags input
   input wire logic cps_exec,
   output logic cps_fault,
   input wire logic sys_periph_acc,
   output logic sys_periph_denied,
   input wire logic [31:0] app_flags_in,
   input wire logic app_flags_we,
   // State seen by the rest of the core
   output logic handler_mode,
   output logic privileged,
   output logic psp_active,
   output logic core_ready,
   output logic [31:0] active_stack_pointer,
   output logic [31:0] program_counter,
   output logic [31:0] program_status_word,
   output logic interrupt_disable_mask,
   output logic fault_disable_mask,
   output logic [7:0] base_priority_mask
);

   // Fixed by the status word layout
   if (EXC_W != 9) begin : g_exc_w_check
      $error("cmp_core_regs: exception field is 9 bits wide");
   end

   // ==========================================================
   // State
   // ==========================================================
   cmp_pkg::cmp_state_t state_r;
   cmp_pkg::cmp_state_t state_nxt;
   logic [31:0] gpr_r [0:12];
   logic [31:0] main_stack_pointer_r;
   logic [31:0] process_stack_pointer_r;
   logic [31:0] return_link_r;
   logic [31:0] program_counter_r;
   logic [31:0] application_flags_r;
   logic [8:0] active_exception_number_r;
   logic [31:0] execution_state_r;
   logic interrupt_disable_mask_r;
   logic fault_disable_mask_r;
   logic [7:0] base_priority_mask_r;
   logic [1:0] thread_control_r;
   logic [31:0] spec_rd_r;
   logic spec_denied_r;
   logic cps_fault_r;
   logic periph_denied_r;
   logic [31:0] gpr_rd_r;
   logic [31:0] push_addr_r;
   logic mem_req_r;
   logic [31:0] mem_addr_r;
   logic core_ready_r;

   // ==========================================================
   // Mode, privilege and stack selection
   // ==========================================================
   wire in_handler = (active_exception_number_r != 9'h000);
   // Handler overrides the control bit entirely
   wire is_priv = in_handler | ~thread_control_r[cmp_pkg::CTRL_NPRIV_BIT];
   wire use_psp = ~in_handler & thread_control_r[cmp_pkg::CTRL_SPSEL_BIT];
   wire [31:0] sp_now = use_psp ? process_stack_pointer_r : main_stack_pointer_r;
   wire run = (state_r == cmp_pkg::CMP_RUN);
   // Decrement first: full descending
   wire [31:0] sp_dec = sp_now - cmp_pkg::STACK_WORD;
   wire [31:0] psw_now = (application_flags_r & cmp_pkg::APP_MASK)
      | {23'h000000, active_exception_number_r}
      | (execution_state_r & cmp_pkg::EXEC_MASK);

   // ==========================================================
   // Special-register decode
   // ==========================================================
   wire [3:0] sel = spec_req.sel;
   wire sel_app = (sel == cmp_pkg::SPEC_APP);
   wire sel_psp = (sel == cmp_pkg::SPEC_PSP);
   // Code 4 is a hole, refused
   wire sel_valid = (sel <= cmp_pkg::SPEC_CTRL) && (sel != 4'h4);
   // Only the flags field and the process pointer are open to either level
   wire sel_either = sel_app | sel_psp;
   wire spec_ok = run & sel_valid & (is_priv | sel_either);
   wire spec_wr = spec_ok & spec_req.we;
   // Codes 0-3 carry the flags field
   wire wr_app = spec_wr & ~sel[2] & (sel[1:0] != 2'h0 || sel_app) & ~sel[3];
   wire wr_msp = spec_wr & (sel == cmp_pkg::SPEC_MSP);
   wire wr_psp = spec_wr & sel_psp;
   wire wr_imask = spec_wr & (sel == cmp_pkg::SPEC_IMASK);
   wire wr_bpri = spec_wr & (sel == cmp_pkg::SPEC_BPRI);
   wire wr_fmask = spec_wr & (sel == cmp_pkg::SPEC_FMASK);
   // Unprivileged attempts fall out here silently, with no fault raised
   wire wr_ctrl = spec_wr & (sel == cmp_pkg::SPEC_CTRL) & is_priv;

   logic [31:0] spec_val;
   always_comb begin
      // Execution-state bits never show through a move
      case (sel)
         cmp_pkg::SPEC_APP: spec_val = application_flags_r & cmp_pkg::APP_MASK;
         cmp_pkg::SPEC_APP_EXC: spec_val = (application_flags_r & cmp_pkg::APP_MASK)
            | {23'h000000, active_exception_number_r};
         cmp_pkg::SPEC_APP_EXEC: spec_val = application_flags_r & cmp_pkg::APP_MASK;
         cmp_pkg::SPEC_PSW: spec_val = (application_flags_r & cmp_pkg::APP_MASK)
            | {23'h000000, active_exception_number_r};
         cmp_pkg::SPEC_EXC: spec_val = {23'h000000, active_exception_number_r};
         cmp_pkg::SPEC_EXEC: spec_val = cmp_pkg::ZERO_RST;
         cmp_pkg::SPEC_EXC_EXEC: spec_val = {23'h000000, active_exception_number_r};
         cmp_pkg::SPEC_MSP: spec_val = main_stack_pointer_r;
         cmp_pkg::SPEC_PSP: spec_val = process_stack_pointer_r;
         cmp_pkg::SPEC_IMASK: spec_val = {31'h00000000, interrupt_disable_mask_r};
         cmp_pkg::SPEC_BPRI: spec_val = {24'h000000, base_priority_mask_r};
         cmp_pkg::SPEC_FMASK: spec_val = {31'h00000000, fault_disable_mask_r};
         cmp_pkg::SPEC_CTRL: spec_val = {30'h00000000, thread_control_r};
         default: spec_val = cmp_pkg::ZERO_RST;
      endcase
   end

   // ==========================================================
   // General register read with R13/R14/R15 aliasing
   // ==========================================================
   logic [31:0] gpr_val;
   always_comb begin
      if (gpr_rd_num == cmp_pkg::REG_SP) begin
         gpr_val = sp_now;
      end else if (gpr_rd_num == cmp_pkg::REG_LINK) begin
         gpr_val = return_link_r;
      end else if (gpr_rd_num == cmp_pkg::REG_PC) begin
         gpr_val = {program_counter_r[31:1], 1'b0};
      end else begin
         gpr_val = gpr_r[gpr_rd_num];
      end
   end

   wire gpr_wr = run & gpr_req.we;
   wire gpr_wr_sp = gpr_wr & (gpr_req.num == cmp_pkg::REG_SP);
   // Pointer write beats a push
   wire do_push = run & push & ~gpr_wr_sp;

   // ==========================================================
   // Reset vector sequence
   // ==========================================================
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         cmp_pkg::CMP_FETCH_SP: if (mem_valid) state_nxt = cmp_pkg::CMP_FETCH_PC;
         cmp_pkg::CMP_FETCH_PC: if (mem_valid) state_nxt = cmp_pkg::CMP_RUN;
         cmp_pkg::CMP_RUN: state_nxt = cmp_pkg::CMP_RUN;
         default: state_nxt = cmp_pkg::CMP_FETCH_SP;
      endcase
   end

   // Nothing is taken before both vectors
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_r <= cmp_pkg::CMP_FETCH_SP;
         mem_req_r <= 1'b0;
         mem_addr_r <= cmp_pkg::VEC_MSP_ADDR;
         core_ready_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         mem_req_r <= (state_nxt != cmp_pkg::CMP_RUN);
         mem_addr_r <= (state_nxt == cmp_pkg::CMP_FETCH_PC) ?
            cmp_pkg::VEC_PC_ADDR : cmp_pkg::VEC_MSP_ADDR;
         core_ready_r <= (state_nxt == cmp_pkg::CMP_RUN);
      end
   end

   // ==========================================================
   // General-purpose registers
   // ==========================================================
   // Zero reset; software must not rely on it
   genvar gi;
   generate
      for (gi = 0; gi < 13; gi++) begin : g_gpr
         always_ff @(posedge sys_clk) begin
            if (!nrst) begin
               gpr_r[gi] <= cmp_pkg::ZERO_RST;
            end else if (gpr_wr && gpr_req.num == 4'(gi)) begin
               gpr_r[gi] <= gpr_req.data;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Stack pointers, link and program counter
   // ==========================================================
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         main_stack_pointer_r <= cmp_pkg::ZERO_RST;
      end else if (state_r == cmp_pkg::CMP_FETCH_SP && mem_valid) begin
         main_stack_pointer_r <= mem_rdata;
      end else if (wr_msp || (gpr_wr_sp && !use_psp)) begin
         main_stack_pointer_r <= wr_msp ? spec_req.data : gpr_req.data;
      end else if (do_push && !use_psp) begin
         main_stack_pointer_r <= sp_dec;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         process_stack_pointer_r <= cmp_pkg::ZERO_RST;
      end else if (wr_psp || (gpr_wr_sp && use_psp)) begin
         process_stack_pointer_r <= wr_psp ? spec_req.data : gpr_req.data;
      end else if (do_push && use_psp) begin
         process_stack_pointer_r <= sp_dec;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         return_link_r <= cmp_pkg::LINK_RST;
      end else if (gpr_wr && gpr_req.num == cmp_pkg::REG_LINK) begin
         return_link_r <= gpr_req.data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         program_counter_r <= cmp_pkg::ZERO_RST;
      end else if (state_r == cmp_pkg::CMP_FETCH_PC && mem_valid) begin
         program_counter_r <= {mem_rdata[31:1], 1'b0};
      end else if (gpr_wr && gpr_req.num == cmp_pkg::REG_PC) begin
         program_counter_r <= {gpr_req.data[31:1], 1'b0};
      end
   end

   // ==========================================================
   // Status word fields and mode
   // ==========================================================
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         application_flags_r <= cmp_pkg::ZERO_RST;
         execution_state_r <= cmp_pkg::EXEC_RST;
      end else if (wr_app) begin
         application_flags_r <= spec_req.data & cmp_pkg::APP_MASK;
      end else if (app_flags_we && run) begin
         application_flags_r <= app_flags_in & cmp_pkg::APP_MASK;
      end
   end

   // Exception number is never written by a move; only supervisor call, entry and return
   // Supervisor call beats entry beats return
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         active_exception_number_r <= 9'h000;
      end else if (run && svc_exec) begin
         active_exception_number_r <= 9'h00b;
      end else if (run && exc_enter) begin
         active_exception_number_r <= exc_num;
      end else if (run && exc_return) begin
         active_exception_number_r <= 9'h000;
      end
   end

   // ==========================================================
   // Masks and thread control
   // ==========================================================
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         interrupt_disable_mask_r <= 1'b0;
         fault_disable_mask_r <= 1'b0;
         base_priority_mask_r <= 8'h00;
         thread_control_r <= 2'h0;
      end else begin
         if (wr_imask) interrupt_disable_mask_r <= spec_req.data[0];
         if (wr_fmask) fault_disable_mask_r <= spec_req.data[0];
         if (wr_bpri) base_priority_mask_r <= spec_req.data[7:0] & cmp_pkg::BPRI_MASK;
         if (wr_ctrl) thread_control_r <= spec_req.data[1:0] & cmp_pkg::CTRL_MASK;
      end
   end

   // ==========================================================
   // Registered answers
   // ==========================================================
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         spec_rd_r <= cmp_pkg::ZERO_RST;
         spec_denied_r <= 1'b0;
         cps_fault_r <= 1'b0;
         periph_denied_r <= 1'b0;
         gpr_rd_r <= cmp_pkg::ZERO_RST;
         push_addr_r <= cmp_pkg::ZERO_RST;
      end else begin
         // Denied reads answer zero
         spec_rd_r <= spec_ok ? spec_val : cmp_pkg::ZERO_RST;
         // Control-register writes from unprivileged code are not denials
         spec_denied_r <= run & ~spec_ok & sel_valid & ~(spec_req.we & sel == cmp_pkg::SPEC_CTRL);
         cps_fault_r <= run & cps_exec & ~is_priv;
         periph_denied_r <= run & sys_periph_acc & ~is_priv;
         gpr_rd_r <= gpr_val;
         if (do_push) push_addr_r <= sp_dec;
      end
   end

   assign mem_req = mem_req_r;
   assign mem_addr = mem_addr_r;
   assign gpr_rd_data = gpr_rd_r;
   assign push_addr = push_addr_r;
   assign spec_rd_data = spec_rd_r;
   assign spec_denied = spec_denied_r;
   assign cps_fault = cps_fault_r;
   assign sys_periph_denied = periph_denied_r;
   assign handler_mode = in_handler;
   assign privileged = is_priv;
   assign psp_active = use_psp;
   assign core_ready = core_ready_r;
   assign active_stack_pointer = sp_now;
   // Loads clear bit 0, so it stays even
   assign program_counter = program_counter_r;
   assign program_status_word = psw_now;
   assign interrupt_disable_mask = interrupt_disable_mask_r;
   assign fault_disable_mask = fault_disable_mask_r;
   assign base_priority_mask = base_priority_mask_r;

endmodule

`default_nettype wire

// >>> hw/cmp_pkg.sv
// Package for the core mode, privilege and register-set block.
// Assumes a single sys_clk domain; shared by the design and its bench.
package cmp_pkg;

   // ==========================================================
   // Register numbers and special-register selectors
   // ==========================================================
   localparam logic [3:0] REG_SP = 4'hd;
   localparam logic [3:0] REG_LINK = 4'he;
   localparam logic [3:0] REG_PC = 4'hf;

   localparam logic [3:0] SPEC_APP = 4'h0;
   localparam logic [3:0] SPEC_APP_EXC = 4'h1;
   localparam logic [3:0] SPEC_APP_EXEC = 4'h2;
   localparam logic [3:0] SPEC_PSW = 4'h3;
   localparam logic [3:0] SPEC_EXC = 4'h5;
   localparam logic [3:0] SPEC_EXEC = 4'h6;
   localparam logic [3:0] SPEC_EXC_EXEC = 4'h7;
   localparam logic [3:0] SPEC_MSP = 4'h8;
   localparam logic [3:0] SPEC_PSP = 4'h9;
   localparam logic [3:0] SPEC_IMASK = 4'ha;
   localparam logic [3:0] SPEC_BPRI = 4'hb;
   localparam logic [3:0] SPEC_FMASK = 4'hc;
   localparam logic [3:0] SPEC_CTRL = 4'hd;

   // ==========================================================
   // Field layouts
   // ==========================================================
   localparam logic [31:0] APP_MASK = 32'hf800_0000;
   localparam logic [31:0] EXC_MASK = 32'h0000_01ff;
   localparam logic [31:0] EXEC_MASK = 32'h0700_fc00;
   localparam int CTRL_NPRIV_BIT = 0;
   localparam int CTRL_SPSEL_BIT = 1;
   localparam logic [1:0] CTRL_MASK = 2'h3;
   localparam logic [7:0] BPRI_MASK = 8'hff;

   // ==========================================================
   // Reset values and vector addresses
   // ==========================================================
   localparam logic [31:0] LINK_RST = 32'hffff_ffff;
   localparam logic [31:0] EXEC_RST = 32'h0100_0000;
   localparam logic [31:0] ZERO_RST = 32'h0000_0000;
   localparam logic [31:0] VEC_MSP_ADDR = 32'h0000_0000;
   localparam logic [31:0] VEC_PC_ADDR = 32'h0000_0004;
   localparam logic [31:0] STACK_WORD = 32'h0000_0004;

   typedef enum logic [1:0] {CMP_FETCH_SP, CMP_FETCH_PC, CMP_RUN} cmp_state_t;

   typedef struct packed {
      logic we;
      logic [3:0] sel;
      logic [31:0] data;
   } cmp_spec_req_t;

   typedef struct packed {
      logic we;
      logic [3:0] num;
      logic [31:0] data;
   } cmp_gpr_req_t;

endpackage

// >>> verification/cmp_core_regs_checker.sv
// Concurrent checks for the core mode, privilege and register-set block.
// Sees only the ports of cmp_core_regs; bound to every instance of it.
`timescale 1ns/1ps
`default_nettype none

module cmp_core_regs_checker (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic exc_enter,
   input wire logic [8:0] exc_num,
   input wire logic exc_return,
   input wire logic svc_exec,
   input wire cmp_pkg::cmp_gpr_req_t gpr_req,
   input wire logic push,
   input wire logic [31:0] push_addr,
   input wire cmp_pkg::cmp_spec_req_t spec_req,
   input wire logic [31:0] spec_rd_data,
   input wire logic spec_denied,
   input wire logic cps_exec,
   input wire logic cps_fault,
   input wire logic sys_periph_acc,
   input wire logic sys_periph_denied,
   input wire logic handler_mode,
   input wire logic privileged,
   input wire logic psp_active,
   input wire logic core_ready,
   input wire logic [31:0] active_stack_pointer,
   input wire logic [31:0] program_counter,
   input wire logic [31:0] program_status_word,
   input wire logic interrupt_disable_mask
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // =====================================
   // Helpers
   // =====================================
   // No mode change in the same cycle, so register effects are unambiguous
   logic quiet;
   assign quiet = !exc_enter && !svc_exec && !exc_return;

   sequence s_svc;
      core_ready && svc_exec;
   endsequence
   sequence s_spec_wr_unpriv;
      core_ready && spec_req.we && !privileged && quiet;
   endsequence

   // =====================================
   // Assertions
   // =====================================
   a_thread_at_start: assert property (!core_ready |-> !handler_mode)
      else $error("handler mode before the core is ready");
   a_enter_handler: assert property (core_ready && exc_enter && exc_num != 9'h0 && !svc_exec
      |=> handler_mode && program_status_word[8:0] == $past(exc_num)) else $error("exception entry wrong");
   a_return_thread: assert property (core_ready && exc_return && !exc_enter && !svc_exec
      |=> !handler_mode && program_status_word[8:0] == 9'h0) else $error("exception return wrong");
   a_handler_priv: assert property (handler_mode |-> privileged)
      else $error("handler mode not privileged");
   a_handler_main_sp: assert property (handler_mode |-> !psp_active)
      else $error("handler mode on process stack");
   a_svc_to_priv: assert property (s_svc |=> handler_mode && privileged && program_status_word[8:0] == 9'h00b)
      else $error("supervisor call not taken");
   a_cps_refused: assert property (core_ready && cps_exec |=> cps_fault == !$past(privileged))
      else $error("state change fault wrong");
   a_periph_denied: assert property (core_ready && sys_periph_acc |=> sys_periph_denied == !$past(privileged))
      else $error("system resource check wrong");
   a_push_dec_first: assert property (core_ready && push && quiet && !gpr_req.we && !spec_req.we
      |=> push_addr == $past(active_stack_pointer) - 32'h4 && active_stack_pointer == push_addr)
      else $error("push address wrong");
   a_pc_even: assert property (core_ready |-> !program_counter[0])
      else $error("program counter odd");
   a_exc_bits_kept: assert property (core_ready && spec_req.we && quiet
      |=> program_status_word[8:0] == $past(program_status_word[8:0])) else $error("exception bits written");
   a_exec_reads_zero: assert property (core_ready && !spec_req.we && spec_req.sel == cmp_pkg::SPEC_EXEC
      |=> spec_rd_data == 32'h0) else $error("execution state read not zero");
   a_mask_denied: assert property (s_spec_wr_unpriv ##0 spec_req.sel == cmp_pkg::SPEC_IMASK
      |=> spec_denied && interrupt_disable_mask == $past(interrupt_disable_mask)) else $error("mask write not refused");
   a_ctrl_drop: assert property (s_spec_wr_unpriv ##0 spec_req.sel == cmp_pkg::SPEC_CTRL
      |=> !privileged && !spec_denied && psp_active == $past(psp_active)) else $error("control write not dropped");
endmodule

bind cmp_core_regs cmp_core_regs_checker i_chk (.sys_clk, .nrst, .exc_enter, .exc_num, .exc_return, .svc_exec,
   .gpr_req, .push, .push_addr, .spec_req, .spec_rd_data, .spec_denied, .cps_exec, .cps_fault, .sys_periph_acc,
   .sys_periph_denied, .handler_mode, .privileged, .psp_active, .core_ready, .active_stack_pointer,
   .program_counter, .program_status_word, .interrupt_disable_mask);

`default_nettype wire

// >>> verification/cmp_core_regs_tb_top.sv
// Self-checking bench for the core mode, privilege and register-set block.
// Drives every port itself, answering vector fetches in place of memory.
`timescale 1ns/1ps
`default_nettype none

module cmp_core_regs_tb_top;
   logic sys_clk, nrst, mem_req, mem_valid, exc_enter, exc_return, svc_exec, push, spec_denied;
   logic cps_exec, cps_fault, sys_periph_acc, sys_periph_denied, app_flags_we, handler_mode, privileged;
   logic psp_active, core_ready, interrupt_disable_mask, fault_disable_mask;
   logic [31:0] mem_addr, mem_rdata, gpr_rd_data, push_addr, spec_rd_data, app_flags_in;
   logic [31:0] active_stack_pointer, program_counter, program_status_word;
   logic [8:0] exc_num;
   logic [3:0] gpr_rd_num;
   logic [7:0] base_priority_mask;
   cmp_pkg::cmp_gpr_req_t gpr_req;
   cmp_pkg::cmp_spec_req_t spec_req;
   int mismatches, n_tests, k;
   logic [3:0] sel_t [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
   logic [31:0] exp_t [7] = '{32'hf800_0000, 32'hf800_0010, 32'hf800_0000, 32'hf800_0010, 32'h10, 32'h0, 32'h10};

   cmp_core_regs i_dut (.sys_clk, .nrst, .mem_req, .mem_addr, .mem_valid, .mem_rdata, .exc_enter, .exc_num,
      .exc_return, .svc_exec, .gpr_req, .gpr_rd_num, .gpr_rd_data, .push, .push_addr, .spec_req, .spec_rd_data,
      .spec_denied, .cps_exec, .cps_fault, .sys_periph_acc, .sys_periph_denied, .app_flags_in, .app_flags_we,
      .handler_mode, .privileged, .psp_active, .core_ready, .active_stack_pointer, .program_counter,
      .program_status_word, .interrupt_disable_mask, .fault_disable_mask, .base_priority_mask);

   initial begin
      sys_clk = 1'h0;
      forever #2 sys_clk = ~sys_clk;
   end

   // =====================================
   // Access tasks
   // =====================================
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("Checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic tmo(input int n);
      if (n >= 20) begin
         mismatches++;
         $display("MISMATCH wait_limit expected 19 seen %0d", n);
         test_done;
      end
   endtask
   // Inputs move 1 ns after the edge so the design samples settled values
   task automatic tick;
      @(posedge sys_clk);
      #1;
   endtask
   // A request stands until the next call replaces it
   task automatic spec(input logic we, input logic [3:0] sel, input logic [31:0] d);
      spec_req = '{we, sel, d};
      tick;
   endtask
   task automatic gpr(input logic we, input logic [3:0] n, input logic [31:0] d);
      gpr_req = '{we, n, d};
      gpr_rd_num = n;
      tick;
   endtask

   // =====================================
   // Main sequence
   // =====================================
   initial begin
      {nrst, mem_valid, exc_enter, exc_return, svc_exec, push, cps_exec, sys_periph_acc, app_flags_we} = '0;
      mem_rdata = 32'h0;
      exc_num = 9'h0;
      app_flags_in = 32'h0;
      gpr_rd_num = 4'h0;
      gpr_req = '{1'h0, 4'h0, 32'h0};
      spec_req = '{1'h0, cmp_pkg::SPEC_APP, 32'h0};
      repeat (16) @(posedge sys_clk);
      #1;
      nrst = 1'h1;
      for (k = 0; k < 20 && mem_req !== 1'h1; k++) tick;
      tmo(k);
      chk("handler_mode", handler_mode, 1'h0);
      chk("mem_addr", mem_addr, 32'h0);
      mem_rdata = 32'h2000_1000;
      mem_valid = 1'h1;
      tick;
      mem_valid = 1'h0;
      for (k = 0; k < 20 && !(mem_req === 1'h1 && mem_addr === 32'h4); k++) tick;
      tmo(k);
      mem_rdata = 32'h0000_0101;
      mem_valid = 1'h1;
      tick;
      mem_valid = 1'h0;
      for (k = 0; k < 20 && core_ready !== 1'h1; k++) tick;
      tmo(k);
      chk("asp", active_stack_pointer, 32'h2000_1000);
      chk("pc", program_counter, 32'h0000_0100);
      chk("psw", program_status_word, 32'h0100_0000);
      chk("mode_priv", {handler_mode, privileged, psp_active}, 3'h2);
      gpr(1'h0, cmp_pkg::REG_LINK, 32'h0);
      chk("link", gpr_rd_data, 32'hffff_ffff);
      $display("test reset done");

      for (k = 0; k < 13; k++) gpr(1'h1, 4'(k), 32'h1111_0000 + 32'(k));
      for (k = 0; k < 13; k++) begin
         gpr(1'h0, 4'(k), 32'h0);
         chk("gpr", gpr_rd_data, 32'h1111_0000 + 32'(k));
      end
      $display("test gpr done");

      spec(1'h1, cmp_pkg::SPEC_PSP, 32'h2000_0800);
      spec(1'h1, cmp_pkg::SPEC_CTRL, 32'h2);
      chk("psp_active", psp_active, 1'h1);
      gpr(1'h0, cmp_pkg::REG_SP, 32'h0);
      chk("r13", gpr_rd_data, 32'h2000_0800);
      spec(1'h0, cmp_pkg::SPEC_APP, 32'h0);
      push = 1'h1;
      tick;
      push = 1'h0;
      chk("push_addr", push_addr, 32'h2000_07fc);
      spec(1'h0, cmp_pkg::SPEC_MSP, 32'h0);
      chk("msp", spec_rd_data, 32'h2000_1000);
      $display("test stack done");

      exc_num = 9'h010;
      exc_enter = 1'h1;
      tick;
      exc_enter = 1'h0;
      chk("handler", {handler_mode, privileged, psp_active}, 3'h6);
      chk("asp_handler", active_stack_pointer, 32'h2000_1000);
      spec(1'h1, cmp_pkg::SPEC_PSW, 32'hffff_ffff);
      for (k = 0; k < 7; k++) begin
         spec(1'h0, sel_t[k], 32'h0);
         chk("psw_view", spec_rd_data, exp_t[k]);
      end
      spec(1'h1, cmp_pkg::SPEC_EXC_EXEC, 32'h0);
      spec(1'h0, cmp_pkg::SPEC_PSW, 32'h0);
      chk("ro_pair", spec_rd_data, 32'hf800_0010);
      spec(1'h1, cmp_pkg::SPEC_APP_EXC, 32'h0);
      spec(1'h0, cmp_pkg::SPEC_PSW, 32'h0);
      chk("rw_pair", spec_rd_data, 32'h10);
      exc_return = 1'h1;
      tick;
      exc_return = 1'h0;
      chk("thread", {handler_mode, psp_active}, 2'h1);
      app_flags_in = 32'h4800_0000;
      app_flags_we = 1'h1;
      tick;
      app_flags_we = 1'h0;
      $display("test exception done");

      spec(1'h1, cmp_pkg::SPEC_CTRL, 32'h3);
      chk("unpriv", privileged, 1'h0);
      spec(1'h0, cmp_pkg::SPEC_MSP, 32'h0);
      chk("msp_denied", {spec_denied, spec_rd_data}, {1'h1, 32'h0});
      spec(1'h0, cmp_pkg::SPEC_PSP, 32'h0);
      chk("psp_read", {spec_denied, spec_rd_data}, {1'h0, 32'h2000_07fc});
      spec(1'h0, cmp_pkg::SPEC_APP, 32'h0);
      chk("flags_read", spec_rd_data, 32'h4800_0000);
      gpr(1'h0, 4'h3, 32'h0);
      chk("gpr_unpriv", gpr_rd_data, 32'h1111_0003);
      {cps_exec, sys_periph_acc} = 2'h3;
      tick;
      {cps_exec, sys_periph_acc} = 2'h0;
      chk("refused", {cps_fault, sys_periph_denied}, 2'h3);
      spec(1'h1, cmp_pkg::SPEC_IMASK, 32'h1);
      chk("mask_denied", {spec_denied, interrupt_disable_mask}, 2'h2);
      spec(1'h1, cmp_pkg::SPEC_CTRL, 32'h0);
      chk("ctrl_drop", {spec_denied, privileged}, 2'h0);
      svc_exec = 1'h1;
      tick;
      svc_exec = 1'h0;
      chk("svc", {handler_mode, privileged}, 2'h3);
      spec(1'h0, cmp_pkg::SPEC_EXC, 32'h0);
      chk("svc_num", spec_rd_data, 32'h0000_000b);
      spec(1'h1, cmp_pkg::SPEC_CTRL, 32'h0);
      exc_return = 1'h1;
      tick;
      exc_return = 1'h0;
      chk("priv_back", {handler_mode, privileged, psp_active}, 3'h2);
      {cps_exec, sys_periph_acc} = 2'h3;
      tick;
      {cps_exec, sys_periph_acc} = 2'h0;
      chk("allowed", {cps_fault, sys_periph_denied}, 2'h0);
      spec(1'h1, cmp_pkg::SPEC_IMASK, 32'h1);
      spec(1'h1, cmp_pkg::SPEC_BPRI, 32'h40);
      spec(1'h1, cmp_pkg::SPEC_FMASK, 32'h1);
      chk("masks", {interrupt_disable_mask, fault_disable_mask, base_priority_mask}, 10'h340);
      gpr(1'h1, cmp_pkg::REG_PC, 32'h0000_0203);
      chk("pc_even", program_counter, 32'h0000_0202);
      $display("test privilege done");
      gpr(1'h1, cmp_pkg::REG_LINK, 32'h0000_1234);
      nrst = 1'h0;
      gpr(1'h0, cmp_pkg::REG_LINK, 32'h0);
      nrst = 1'h1;
      chk("rst_clear", {core_ready, mem_req, interrupt_disable_mask, base_priority_mask}, 11'h0);
      tick;
      chk("rst_link", gpr_rd_data, 32'hffff_ffff);
      chk("rst_mode", {mem_req, handler_mode, privileged}, 3'h5);
      $display("test rerun done");
      test_done;
   end
endmodule

`default_nettype wire
